//--- rtl/codec_regs_defines.svh
`ifndef CODEC_REGS_DEFINES_SVH
`define CODEC_REGS_DEFINES_SVH

`define OFS_STATUS_A 16'h1b77
`define OFS_STATUS_B 16'h1b78
`define OFS_MASK_A 16'h1b79
`define OFS_MASK_B 16'h1b7a
`define OFS_BIAS 16'h1c03
`define OFS_CAP_CTL 16'h1d01
`define OFS_CAP_RAMP 16'h1d02
`define OFS_CAP_VOL 16'h1d03
`define OFS_CAP_FILT 16'h1d04
`define OFS_PB_A 16'h1f01
`define OFS_PB_B 16'h1f06
`define OFS_HP 16'h2001

`define RST_MASK_A 8'he0
`define RST_MASK_B 8'hff
`define RST_BIAS 8'hc2
`define RST_CAP_CTL 8'h00
`define RST_CAP_RAMP 8'h02
`define RST_CAP_VOL 8'h00
`define RST_CAP_FILT 8'h71
`define RST_PB_A 8'h00
`define RST_PB_B 8'h02
`define RST_HP 8'h0d

`define WM_MASK_A 8'he0
`define WM_MASK_B 8'hc7
`define WM_BIAS 8'h93
`define WM_CAP_CTL 8'h35
`define WM_CAP_RAMP 8'h04
`define WM_CAP_VOL 8'hff
`define WM_CAP_FILT 8'h7f
`define WM_PB_A 8'h03
`define WM_PB_B 8'hfe
`define WM_HP 8'h0e

`define BIT_TIP 7
`define BIT_FLOAT 6
`define BIT_LEVEL 1
`define BIT_SHORT 0
`define BIT_M_SENSE 7
`define BIT_M_PLUG 6
`define BIT_M_UNPLUG 5
`define BIT_M_LVL_FALL 7
`define BIT_M_LVL_RISE 6
`define BIT_M_FLOAT 2
`define BIT_M_RELEASE 1
`define BIT_M_PRESS 0
`define BIT_BIAS_PD 4
`define BIT_NOTCH_DIS 5
`define BIT_WEAK_VCM 4
`define BIT_CAP_INV 2
`define BIT_CAP_BOOST 0
`define BIT_CAP_RAMP 2
`define BIT_WIND_EN 3
`define BIT_HPF_EN 0
`define BIT_HP_LOAD 3
`define BIT_HP_CLAMP 2
`define BIT_DAC_HPF 1
`define PULLDOWN_FIRST_RSVD 4'hd
`define GAIN_MUTE_TOP 8'h9f
`define GAIN_MUTE_BOT 8'h80

`define CLK_MHZ 200
`define DEB_200_MS 200
`define DEB_500_MS 500
`define DEB_1000_MS 1000
`define CYCLES_PER_MS (`CLK_MHZ * 1000)

`endif

//--- rtl/codec_regs_pkg.sv
package codec_regs_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {RAMP_FAST_SLOWFALL, RAMP_FAST, RAMP_SLOW, RAMP_SLOWEST} ramp_sel_t;
  typedef enum logic [1:0] {DEB_NONE, DEB_200, DEB_500, DEB_1000} debounce_sel_t;
endpackage : codec_regs_pkg

//--- rtl/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,               // core clock
  input wire logic resetn,             // async reset, active low
  input wire logic [WIDTH-1:0] pin_in, // asynchronous level
  output logic [WIDTH-1:0] level_q     // filtered level
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("pin_sync3 needs WIDTH of at least 1");
    end
  endgenerate

  // a bit moves only once stages two and three agree
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_q);
    end
  end
endmodule : pin_sync3

//--- rtl/unplug_debounce.sv
`timescale 1ns/1ps
`include "codec_regs_defines.svh"
module unplug_debounce #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire logic mclk,          // core clock
  input wire logic resetn,        // async reset, active low
  input wire logic plugged,       // synchronised tip level
  input wire logic [1:0] sel,     // debounce selection
  output logic state_q            // debounced plug state
);
  localparam int CW = 32;
  logic [CW-1:0] cnt_q, limit;

  generate
    if (CYCLES_PER_MS < 1)
    begin : g_chk
      $error("unplug_debounce needs CYCLES_PER_MS of at least 1");
    end
  endgenerate

  always_comb
  begin
    case (codec_regs_pkg::debounce_sel_t'(sel))
      codec_regs_pkg::DEB_200: limit = CW'(`DEB_200_MS * CYCLES_PER_MS);
      codec_regs_pkg::DEB_500: limit = CW'(`DEB_500_MS * CYCLES_PER_MS);
      codec_regs_pkg::DEB_1000: limit = CW'(`DEB_1000_MS * CYCLES_PER_MS);
      default: limit = '0;
    endcase
  end

  // plug reports at once, unplug only after a full quiet period
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      state_q <= 1'b0;
    end
    else if (plugged || !state_q)
    begin
      cnt_q <= '0;
      state_q <= plugged;
    end
    else if (cnt_q >= limit)
    begin
      cnt_q <= '0;
      state_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule : unplug_debounce

//--- rtl/headset_detect_adc_dac_regs.sv
`timescale 1ns/1ps
`include "codec_regs_defines.svh"
// Functional notes
// - status A bit 7 shows plug state; unplug reported after debounce
// - status A bit 6 shows whether bias float mode is on
// - status B bit 1 set while the level comparator reads below threshold
// - status B bit 0 follows the filtered button-short comparator
// - mask A bits 7,6,5 block sense, plug, unplug; reset masked
// - mask B bits 7,6,2,1,0 block events; release bit shadowed twice
// - each read of mask B with a shadow queued moves it into release bit, not in standby
// - press mask reaches standby only while domain transfer is on
// - bias control bit 4 switches the bias pulldown on
// - bias bits 1:0 pick the bias ramp, slow at reset
// - capture control bit 5 bypasses the notch filter
// - capture control bit 2 inverts capture samples
// - capture control bit 0 adds fixed 20 dB gain
// - soft ramp bit 2 makes capture gain step gradually
// - playback control A bits 1:0 invert each channel
// - pulldown select in bits 7:4; codes 1101 to 1111 reserved
// - load bit picks 1 nF or 10 nF; software powers path down first
// - unplug debounce is none, 200, 500 or 1000 ms
module headset_detect_adc_dac_regs #(
  parameter int CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter int SAMPLE_W = 24
) (
  input wire logic mclk,                     // 200 MHz core clock
  input wire logic resetn,                   // async reset, active low
  input wire logic [15:0] reg_addr,          // register address
  input wire logic reg_wr,                   // write strobe
  input wire logic reg_rd,                   // read strobe
  input wire logic [7:0] reg_wdata,          // write data
  output logic [7:0] reg_rdata_q,            // read data
  input wire logic tip_sense_pin,            // tip sense, high when plugged
  input wire logic bias_float_pin,           // bias float mode level
  input wire logic level_below_pin,          // level comparator output
  input wire logic short_below_pin,          // button short comparator output
  input wire logic bias_trip_pin,            // bias current sense trip
  input wire logic [1:0] tip_debounce_sel,   // unplug debounce selection
  input wire logic standby_domain_transfer,  // transparent transfer enable
  input wire logic standby_only,             // only standby supply present
  input wire logic ramp_tick,                // shared soft-ramp rate pulse
  input wire logic [SAMPLE_W-1:0] cap_in,    // capture sample in
  input wire logic cap_in_valid,             // capture sample strobe
  output logic [SAMPLE_W-1:0] cap_out_q,     // processed capture sample
  output logic cap_out_valid_q,              // processed sample strobe
  output logic [7:0] capture_gain_q,         // gain code in effect
  output logic capture_mute,                 // gain code is in mute range
  output logic [7:0] detect_event,           // unmasked event pulses
  output logic mask_press_standby_q,         // press mask in standby domain
  output logic bias_pulldown_enable,         // bias pulldown switch
  output logic [1:0] bias_ramp_select,       // bias ramp rate
  output logic bias_capless,                 // no bias capacitor
  output logic notch_bypass,                 // capture notch bypass
  output logic weak_vcm_force,               // capture weak vcm force
  output logic [2:0] wind_filter_corner,     // wind filter corner
  output logic wind_filter_enable,           // wind filter on
  output logic [1:0] capture_highpass_corner, // capture hpf corner
  output logic capture_highpass_enable,      // capture hpf on
  output logic [1:0] playback_channel_invert, // playback invert per channel
  output logic [3:0] headphone_pulldown_select, // output pulldown code
  output logic headphone_load_mode,          // 1 selects 10 nF mode
  output logic headphone_clamp_off,          // output clamp disable
  output logic playback_highpass_enable,     // playback hpf on
  output logic [2:0] headphone_misc          // mute b, mute a, full scale
);
  localparam int NRW = 10;
  localparam logic [3:0] IX_NONE = 4'hf;
  localparam logic [3:0] IX_STA = 4'ha;
  localparam logic [3:0] IX_STB = 4'hb;
  localparam logic [15:0] OFS_TAB [NRW] = '{
    `OFS_MASK_A,
    `OFS_MASK_B,
    `OFS_BIAS,
    `OFS_CAP_CTL,
    `OFS_CAP_RAMP,
    `OFS_CAP_VOL,
    `OFS_CAP_FILT,
    `OFS_PB_A,
    `OFS_PB_B,
    `OFS_HP};
  localparam logic [7:0] RST_TAB [NRW] = '{
    `RST_MASK_A,
    `RST_MASK_B,
    `RST_BIAS,
    `RST_CAP_CTL,
    `RST_CAP_RAMP,
    `RST_CAP_VOL,
    `RST_CAP_FILT,
    `RST_PB_A,
    `RST_PB_B,
    `RST_HP};
  localparam logic [7:0] WM_TAB [NRW] = '{
    `WM_MASK_A,
    `WM_MASK_B,
    `WM_BIAS,
    `WM_CAP_CTL,
    `WM_CAP_RAMP,
    `WM_CAP_VOL,
    `WM_CAP_FILT,
    `WM_PB_A,
    `WM_PB_B,
    `WM_HP};

  generate
    if (SAMPLE_W < 8)
    begin : g_chk
      $error("SAMPLE_W must be at least 8");
    end
  endgenerate

  function automatic logic [3:0] reg_index(input logic [15:0] a);
    logic [3:0] r;
    r = IX_NONE;
    if (a == `OFS_STATUS_A)
      r = IX_STA;
    if (a == `OFS_STATUS_B)
      r = IX_STB;
    for (int k = 0; k < NRW; k++)
      if (a == OFS_TAB[k])
        r = 4'(k);
    return r;
  endfunction : reg_index

  codec_regs_pkg::reg_byte_t rw_q [NRW];
  logic [3:0] wr_ix, rd_ix;
  logic [7:0] wdata_fix;
  logic [4:0] pin_lvl;
  logic tip_lvl, float_lvl, level_lvl, short_lvl, trip_lvl;
  logic tip_state;
  logic [4:0] prev_q;
  logic plug_ev, unplug_ev, sense_ev, lvl_rise_ev, lvl_fall_ev;
  logic float_ev, press_ev, release_ev;
  logic [7:0] status_a, status_b, mask_b_view;
  logic [1:0] shadow_cnt_q;
  logic shadow0_q, shadow1_q, release_vis_q;
  logic rd_mask_b, wr_mask_b, shadow_on, pop, push;

  assign wr_ix = reg_wr ? reg_index(reg_addr) : IX_NONE;
  assign rd_ix = reg_index(reg_addr);

  // a reserved pulldown code is refused and the field keeps its value
  assign wdata_fix = (wr_ix == 4'd8 && reg_wdata[7:4] >= `PULLDOWN_FIRST_RSVD) ?
    {rw_q[8][7:4], reg_wdata[3:0]} : reg_wdata;

  genvar gi;
  generate
    for (gi = 0; gi < NRW; gi++)
    begin : g_rw
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
          rw_q[gi] <= RST_TAB[gi];
        else if (wr_ix == 4'(gi))
          rw_q[gi] <= (rw_q[gi] & ~WM_TAB[gi]) | (wdata_fix & WM_TAB[gi]);
      end
    end
  endgenerate

  pin_sync3 #(
    .WIDTH(5)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .pin_in({tip_sense_pin, bias_float_pin, level_below_pin, short_below_pin, bias_trip_pin}),
    .level_q(pin_lvl)
  );

  assign tip_lvl = pin_lvl[4];
  assign float_lvl = pin_lvl[3];
  assign level_lvl = pin_lvl[2];
  assign short_lvl = pin_lvl[1];
  assign trip_lvl = pin_lvl[0];

  unplug_debounce #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_deb (
    .mclk(mclk),
    .resetn(resetn),
    .plugged(tip_lvl),
    .sel(tip_debounce_sel),
    .state_q(tip_state)
  );

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      prev_q <= '0;
    else
      prev_q <= {tip_state, float_lvl, level_lvl, short_lvl, trip_lvl};
  end

  assign plug_ev = tip_state & ~prev_q[4];
  assign unplug_ev = ~tip_state & prev_q[4];
  assign float_ev = float_lvl & ~prev_q[3];
  assign lvl_rise_ev = level_lvl & ~prev_q[2];
  assign lvl_fall_ev = ~level_lvl & prev_q[2];
  assign press_ev = short_lvl & ~prev_q[1];
  assign release_ev = ~short_lvl & prev_q[1];
  assign sense_ev = trip_lvl & ~prev_q[0];

  assign status_a = {tip_state, float_lvl, 6'h00};
  assign status_b = {6'h00, level_lvl, short_lvl};

  // release mask: outside standby, each press queues the written value, up to two deep,
  // and every read of mask B while the queue is not empty advances it into the visible bit
  assign shadow_on = ~standby_only;
  assign rd_mask_b = reg_rd && rd_ix == 4'd1;
  assign wr_mask_b = wr_ix == 4'd1;
  assign pop = shadow_on && rd_mask_b && shadow_cnt_q != 2'd0;
  assign push = shadow_on && press_ev && (shadow_cnt_q != 2'd2 || pop);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      shadow_cnt_q <= 2'd0;
      shadow0_q <= 1'b1;
      shadow1_q <= 1'b1;
      release_vis_q <= 1'b1;
    end
    else if (wr_mask_b || !shadow_on)
    begin
      shadow_cnt_q <= 2'd0;
      release_vis_q <= rw_q[1][`BIT_M_RELEASE];
      if (wr_mask_b)
        release_vis_q <= reg_wdata[`BIT_M_RELEASE];
    end
    else
    begin
      if (pop)
      begin
        release_vis_q <= shadow0_q;
        shadow0_q <= shadow1_q;
      end
      if (push && (shadow_cnt_q == 2'd0 || (shadow_cnt_q == 2'd1 && pop)))
        shadow0_q <= rw_q[1][`BIT_M_RELEASE];
      else if (push)
        shadow1_q <= rw_q[1][`BIT_M_RELEASE];
      shadow_cnt_q <= shadow_cnt_q + 2'(push) - 2'(pop);
    end
  end

  assign mask_b_view = {rw_q[1][7:2], release_vis_q, rw_q[1][0]};

  // press mask crosses to the standby copy only in transparent mode
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      mask_press_standby_q <= 1'b1;
    else if (standby_domain_transfer)
      mask_press_standby_q <= rw_q[1][`BIT_M_PRESS];
  end

  assign detect_event[7] = sense_ev & ~rw_q[0][`BIT_M_SENSE];
  assign detect_event[6] = plug_ev & ~rw_q[0][`BIT_M_PLUG];
  assign detect_event[5] = unplug_ev & ~rw_q[0][`BIT_M_UNPLUG];
  assign detect_event[4] = lvl_fall_ev & ~rw_q[1][`BIT_M_LVL_FALL];
  assign detect_event[3] = lvl_rise_ev & ~rw_q[1][`BIT_M_LVL_RISE];
  assign detect_event[2] = float_ev & ~rw_q[1][`BIT_M_FLOAT];
  assign detect_event[1] = release_ev & ~release_vis_q;
  assign detect_event[0] = press_ev & ~rw_q[1][`BIT_M_PRESS];

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (rd_ix)
        IX_STA: reg_rdata_q <= status_a;
        IX_STB: reg_rdata_q <= status_b;
        4'd1: reg_rdata_q <= mask_b_view;
        IX_NONE: reg_rdata_q <= 8'h00;
        default: reg_rdata_q <= rw_q[rd_ix];
      endcase
    end
  end

  assign bias_pulldown_enable = rw_q[2][`BIT_BIAS_PD];
  assign bias_ramp_select = rw_q[2][1:0];
  assign bias_capless = rw_q[2][7];
  assign notch_bypass = rw_q[3][`BIT_NOTCH_DIS];
  assign weak_vcm_force = rw_q[3][`BIT_WEAK_VCM];
  assign wind_filter_corner = rw_q[6][6:4];
  assign wind_filter_enable = rw_q[6][`BIT_WIND_EN];
  assign capture_highpass_corner = rw_q[6][2:1];
  assign capture_highpass_enable = rw_q[6][`BIT_HPF_EN];
  assign playback_channel_invert = rw_q[7][1:0];
  assign headphone_pulldown_select = rw_q[8][7:4];
  assign headphone_load_mode = rw_q[8][`BIT_HP_LOAD];
  assign headphone_clamp_off = rw_q[8][`BIT_HP_CLAMP];
  assign playback_highpass_enable = rw_q[8][`BIT_DAC_HPF];
  assign headphone_misc = rw_q[9][3:1];

  // gain steps one code per ramp tick; signed compare keeps +12 to -96 order
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      capture_gain_q <= `RST_CAP_VOL;
    else if (!rw_q[4][`BIT_CAP_RAMP])
      capture_gain_q <= rw_q[5];
    else if (ramp_tick && $signed(capture_gain_q) < $signed(rw_q[5]))
      capture_gain_q <= capture_gain_q + 8'h01;
    else if (ramp_tick && $signed(capture_gain_q) > $signed(rw_q[5]))
      capture_gain_q <= capture_gain_q - 8'h01;
  end

  assign capture_mute = capture_gain_q >= `GAIN_MUTE_BOT &&
    capture_gain_q <= `GAIN_MUTE_TOP;

  // sample path: invert then boost by ten, both saturating
  localparam logic signed [SAMPLE_W+3:0] SMAX = (SAMPLE_W+4)'({1'b0, {(SAMPLE_W-1){1'b1}}});
  localparam logic signed [SAMPLE_W+3:0] SMIN = -SMAX - (SAMPLE_W+4)'(1);
  logic signed [SAMPLE_W+3:0] s_ext, s_inv, s_boost;
  logic [SAMPLE_W-1:0] s_sat;

  assign s_ext = (SAMPLE_W+4)'($signed(cap_in));
  assign s_inv = rw_q[3][`BIT_CAP_INV] ? -s_ext : s_ext;
  assign s_boost = rw_q[3][`BIT_CAP_BOOST] ?
    ((s_inv <<< 3) + (s_inv <<< 1)) : s_inv;
  assign s_sat = (s_boost > SMAX) ? SMAX[SAMPLE_W-1:0] :
    (s_boost < SMIN) ? SMIN[SAMPLE_W-1:0] : s_boost[SAMPLE_W-1:0];

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_out_q <= '0;
      cap_out_valid_q <= 1'b0;
    end
    else
    begin
      cap_out_valid_q <= cap_in_valid;
      if (cap_in_valid)
        cap_out_q <= capture_mute ? '0 : s_sat;
    end
  end
endmodule : headset_detect_adc_dac_regs

//--- verif/headset_detect_adc_dac_regs_chk.sv
`timescale 1ns/1ps
`include "codec_regs_defines.svh"
module headset_detect_adc_dac_regs_chk (
  input wire logic mclk,                        // core clock
  input wire logic resetn,                      // async reset, active low
  input wire logic [15:0] reg_addr,             // register address
  input wire logic reg_wr,                      // write strobe
  input wire logic reg_rd,                      // read strobe
  input wire logic [7:0] reg_wdata,             // write data
  input wire logic [7:0] reg_rdata_q,           // read data
  input wire logic standby_domain_transfer,     // transfer enable
  input wire logic cap_in_valid,                // sample strobe in
  input wire logic cap_out_valid_q,             // sample strobe out
  input wire logic [7:0] capture_gain_q,        // gain in effect
  input wire logic capture_mute,                // mute flag
  input wire logic mask_press_standby_q,        // standby press mask
  input wire logic bias_pulldown_enable,        // bias pulldown
  input wire logic [1:0] bias_ramp_select,      // bias ramp
  input wire logic bias_capless,                // no bias capacitor
  input wire logic notch_bypass,                // notch bypass
  input wire logic [2:0] wind_filter_corner,    // wind corner
  input wire logic wind_filter_enable,          // wind filter on
  input wire logic [1:0] capture_highpass_corner, // hpf corner
  input wire logic capture_highpass_enable,     // hpf on
  input wire logic [1:0] playback_channel_invert, // playback invert
  input wire logic [3:0] headphone_pulldown_select, // pulldown code
  input wire logic headphone_load_mode          // load mode
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_bias_wr;
    reg_wr && reg_addr == `OFS_BIAS;
  endsequence
  sequence s_pb_b_wr;
    reg_wr && reg_addr == `OFS_PB_B;
  endsequence

  a_bias_pd_write: assert property (s_bias_wr |=> bias_pulldown_enable == $past(reg_wdata[4]))
    else $error("bias pulldown wrong");
  a_bias_ramp_write: assert property (s_bias_wr |=> bias_ramp_select == $past(reg_wdata[1:0]))
    else $error("bias ramp wrong");
  a_notch_write: assert property (reg_wr && reg_addr == `OFS_CAP_CTL |=>
    notch_bypass == $past(reg_wdata[5]))
    else $error("notch bypass wrong");
  a_filter_write: assert property (reg_wr && reg_addr == `OFS_CAP_FILT |=> {wind_filter_corner,
    wind_filter_enable, capture_highpass_corner, capture_highpass_enable} == $past(reg_wdata[6:0]))
    else $error("filter fields wrong");
  a_invert_write: assert property (reg_wr && reg_addr == `OFS_PB_A |=>
    playback_channel_invert == $past(reg_wdata[1:0]))
    else $error("playback invert wrong");
  a_pulldown_write: assert property (s_pb_b_wr ##0 (reg_wdata[7:4] < `PULLDOWN_FIRST_RSVD) |=>
    headphone_pulldown_select == $past(reg_wdata[7:4]))
    else $error("pulldown code not taken");
  a_pulldown_rsvd: assert property (s_pb_b_wr ##0 (reg_wdata[7:4] >= `PULLDOWN_FIRST_RSVD) |=>
    $stable(headphone_pulldown_select))
    else $error("reserved pulldown code taken");
  a_load_write: assert property (s_pb_b_wr |=> headphone_load_mode == $past(reg_wdata[3]))
    else $error("load mode wrong");
  a_mute_range: assert property (capture_mute ==
    (capture_gain_q >= `GAIN_MUTE_BOT && capture_gain_q <= `GAIN_MUTE_TOP))
    else $error("mute flag wrong");
  a_bias_readback: assert property (reg_rd && !reg_wr && reg_addr == `OFS_BIAS |=> reg_rdata_q ==
    {$past(bias_capless), 2'b10, $past(bias_pulldown_enable), 2'b00, $past(bias_ramp_select)})
    else $error("bias readback wrong");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
  a_standby_hold: assert property ((!standby_domain_transfer) [*3] |=>
    $stable(mask_press_standby_q))
    else $error("standby mask moved");
  a_sample_valid: assert property (cap_in_valid |=> cap_out_valid_q)
    else $error("sample strobe missing");
endmodule : headset_detect_adc_dac_regs_chk

bind headset_detect_adc_dac_regs headset_detect_adc_dac_regs_chk chk_inst (.*);

//--- verif/headset_detect_adc_dac_regs_test.sv
`timescale 1ns/1ps
`include "codec_regs_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module headset_detect_adc_dac_regs_test;
  localparam int CYC = 2;
  localparam int MS [4] = '{0, `DEB_200_MS, `DEB_500_MS, `DEB_1000_MS};
  localparam logic [15:0] OFS [10] = '{`OFS_MASK_A, `OFS_MASK_B, `OFS_BIAS, `OFS_CAP_CTL,
    `OFS_CAP_RAMP, `OFS_CAP_VOL, `OFS_CAP_FILT, `OFS_PB_A, `OFS_PB_B, `OFS_HP};
  localparam logic [7:0] RST [10] = '{`RST_MASK_A, `RST_MASK_B, `RST_BIAS, `RST_CAP_CTL,
    `RST_CAP_RAMP, `RST_CAP_VOL, `RST_CAP_FILT, `RST_PB_A, `RST_PB_B, `RST_HP};
  localparam logic [7:0] WM [10] = '{`WM_MASK_A, `WM_MASK_B, `WM_BIAS, `WM_CAP_CTL,
    `WM_CAP_RAMP, `WM_CAP_VOL, `WM_CAP_FILT, `WM_PB_A, `WM_PB_B, `WM_HP};
  logic mclk, resetn, reg_wr, reg_rd, tip_sense_pin, bias_float_pin, level_below_pin;
  logic short_below_pin, bias_trip_pin, standby_domain_transfer, standby_only, ramp_tick;
  logic cap_in_valid, cap_out_valid_q, capture_mute, mask_press_standby_q, bias_pulldown_enable;
  logic notch_bypass, headphone_load_mode;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, capture_gain_q, detect_event;
  logic [1:0] tip_debounce_sel, bias_ramp_select, playback_channel_invert;
  logic [3:0] headphone_pulldown_select;
  logic [23:0] cap_in, cap_out_q;
  int err_total, compares, n;
  integer seed = 32'hfaa1;
  codec_regs_pkg::reg_byte_t q, w;
  codec_regs_pkg::reg_byte_t shadow [10];

  headset_detect_adc_dac_regs #(.CYCLES_PER_MS(CYC)) headset_detect_adc_dac_regs_inst (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .tip_sense_pin(tip_sense_pin),
    .bias_float_pin(bias_float_pin), .level_below_pin(level_below_pin),
    .short_below_pin(short_below_pin), .bias_trip_pin(bias_trip_pin),
    .tip_debounce_sel(tip_debounce_sel), .standby_domain_transfer(standby_domain_transfer),
    .standby_only(standby_only), .ramp_tick(ramp_tick), .cap_in(cap_in),
    .cap_in_valid(cap_in_valid), .cap_out_q(cap_out_q), .cap_out_valid_q(cap_out_valid_q),
    .capture_gain_q(capture_gain_q), .capture_mute(capture_mute), .detect_event(detect_event),
    .mask_press_standby_q(mask_press_standby_q), .bias_pulldown_enable(bias_pulldown_enable),
    .bias_ramp_select(bias_ramp_select), .bias_capless(), .notch_bypass(notch_bypass),
    .weak_vcm_force(), .wind_filter_corner(), .wind_filter_enable(),
    .capture_highpass_corner(), .capture_highpass_enable(),
    .playback_channel_invert(playback_channel_invert),
    .headphone_pulldown_select(headphone_pulldown_select),
    .headphone_load_mode(headphone_load_mode), .headphone_clamp_off(),
    .playback_highpass_enable(), .headphone_misc()
  );

  function automatic codec_regs_pkg::reg_byte_t exp_reg(int i, logic [7:0] d, logic [7:0] p);
    codec_regs_pkg::reg_byte_t r;
    r = (d & WM[i]) | (p & ~WM[i]);
    if (i == 8 && d[7:4] >= `PULLDOWN_FIRST_RSVD)
      r[7:4] = p[7:4];
    return r;
  endfunction : exp_reg

  function automatic logic [23:0] cap_exp(logic signed [23:0] x, logic inv, logic boost);
    logic signed [31:0] y;
    y = x;
    if (inv)
      y = -y;
    if (boost)
      y = y * 10;
    if (y > 32'sh7fffff)
      y = 32'sh7fffff;
    if (y < -32'sh800000)
      y = -32'sh800000;
    return y[23:0];
  endfunction : cap_exp

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata_q;
  endtask : rd

  // events last one cycle: look at every one
  task automatic count_ev(input int b, output int c);
    c = 0;
    repeat (10)
    begin
      @(negedge mclk);
      if (detect_event[b] === 1'b1)
        c++;
    end
  endtask : count_ev

  task automatic cap_chk(input logic [23:0] x, input logic [23:0] e);
    cap_in = x;
    cap_in_valid = 1'b1;
    @(negedge mclk);
    cap_in_valid = 1'b0;
    `CHK(cap_out_valid_q, 1'b1)
    `CHK(cap_out_q, e)
  endtask : cap_chk

  task automatic complete_run();
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    repeat (40000) @(posedge mclk);
    err_total++;
    complete_run();
  end

  initial
  begin
    {resetn, reg_wr, reg_rd, tip_sense_pin, bias_float_pin, level_below_pin} = '0;
    {short_below_pin, bias_trip_pin, standby_domain_transfer, standby_only} = '0;
    {ramp_tick, cap_in_valid, reg_addr, reg_wdata, cap_in} = '0;
    tip_debounce_sel = 2'b10;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    for (int i = 0; i < 10; i++)
    begin
      rd(OFS[i], q);
      `CHK(q, RST[i])
      shadow[i] = RST[i];
    end
    // corner values first, then random
    for (int k = 0; k < 6; k++)
      for (int i = 0; i < 10; i++)
      begin
        w = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : (k == 2) ? 8'hd5 : 8'($random(seed));
        if (i == 6) w[0] = 1'b1;
        wr(OFS[i], w);
        shadow[i] = exp_reg(i, w, shadow[i]);
        rd(OFS[i], q);
        `CHK(q, shadow[i])
      end
    `CHK(bias_pulldown_enable, shadow[2][4])
    `CHK(bias_ramp_select, shadow[2][1:0])
    `CHK(notch_bypass, shadow[3][5])
    `CHK(playback_channel_invert, shadow[7][1:0])
    `CHK(headphone_pulldown_select, shadow[8][7:4])
    `CHK(headphone_load_mode, shadow[8][3])
    wr(16'h1b7b, 8'h5a);
    rd(16'h1b7b, q);
    `CHK(q, 8'h00)
    wr(`OFS_STATUS_B, 8'hff);
    rd(`OFS_STATUS_B, q);
    `CHK(q, 8'h00)
    wr(`OFS_MASK_A, 8'h00);
    wr(`OFS_MASK_B, 8'h3a);
    tip_sense_pin = 1'b1;
    count_ev(6, n);
    `CHK(n, 1)
    short_below_pin = 1'b1;
    count_ev(0, n);
    `CHK(n, 1)
    short_below_pin = 1'b0;
    count_ev(1, n);
    `CHK(n, 0)
    bias_trip_pin = 1'b1;
    count_ev(7, n);
    `CHK(n, 1)
    {bias_float_pin, level_below_pin, short_below_pin} = 3'b111;
    count_ev(3, n);
    `CHK(n, 1)
    rd(`OFS_STATUS_A, q);
    `CHK(q, 8'hc0)
    rd(`OFS_STATUS_B, q);
    `CHK(q, 8'h03)
    for (int s = 0; s < 4; s++)
    begin
      tip_debounce_sel = 2'(s);
      tip_sense_pin = 1'b1;
      repeat (20) @(negedge mclk);
      tip_sense_pin = 1'b0;
      if (s != 0)
      begin
        repeat (MS[s] * CYC - 6) @(negedge mclk);
        rd(`OFS_STATUS_A, q);
        `CHK(q[7], 1'b1)
      end
      repeat ((s != 0) ? 14 : 8) @(negedge mclk);
      rd(`OFS_STATUS_A, q);
      `CHK(q[7], 1'b0)
    end
    `CHK(mask_press_standby_q, 1'b1)
    standby_domain_transfer = 1'b1;
    repeat (4) @(negedge mclk);
    `CHK(mask_press_standby_q, 1'b0)
    wr(`OFS_CAP_VOL, 8'h00);
    wr(`OFS_CAP_RAMP, 8'h00);
    wr(`OFS_CAP_CTL, 8'h05);
    cap_chk(24'h100000, cap_exp(24'h100000, 1'b1, 1'b1));
    for (int k = 0; k < 8; k++)
    begin
      cap_in = 24'($random(seed) % 65536);
      cap_chk(cap_in, cap_exp(cap_in, 1'b1, 1'b1));
    end
    wr(`OFS_CAP_CTL, 8'h00);
    cap_chk(24'h0003e8, 24'h0003e8);
    wr(`OFS_CAP_VOL, 8'h90);
    repeat (2) @(negedge mclk);
    `CHK(capture_gain_q, 8'h90)
    `CHK(capture_mute, 1'b1)
    cap_chk(24'h000064, 24'h000000);
    wr(`OFS_CAP_VOL, 8'ha0);
    repeat (2) @(negedge mclk);
    `CHK(capture_mute, 1'b0)
    wr(`OFS_CAP_VOL, 8'h00);
    wr(`OFS_CAP_RAMP, 8'h04);
    wr(`OFS_CAP_VOL, 8'h05);
    repeat (3) @(negedge mclk);
    `CHK(capture_gain_q, 8'h00)
    repeat (5)
    begin
      ramp_tick = 1'b1;
      @(negedge mclk);
      ramp_tick = 1'b0;
      @(negedge mclk);
    end
    `CHK(capture_gain_q, 8'h05)
    complete_run();
  end
endmodule : headset_detect_adc_dac_regs_test
